//--- pbr_bank.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module pbr_bank (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_up,
   input wire logic event_pending,
   input wire logic shared_irq_sleep_pin_i,
   output logic shared_irq_sleep_pin_o,
   output logic shared_irq_sleep_pin_oe_n,
   output pbr_pkg::pbr_ctl_s core_ctl,
   output logic irq
);
   import pbr_pkg::*;

   logic [15:0] ctrl_r;
   logic [15:0] cfg_r;
   logic irq_seen_r;
   logic link_r;
   logic link_d_r;
   logic [PBR_NUM_EV-1:0] ev_stat_r;
   logic [PBR_NUM_EV-1:0] ev_mask_r;
   logic [PBR_NUM_EV-1:0] ev_in;
   logic srst_r;
   logic pin_active;
   logic pin_active_d_r;
   logic irq_drive;
   logic wr_acc;
   logic rd_acc;
   logic hit;
   logic [15:0] rd_mux;
   logic [3:0] depth;
   logic all_rst;
   pbr_pin_s pin_nxt;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   // one wait state: setup, access, pready; keeps the read path registered
   assign wr_acc = psel & penable & pwrite & ~pready;
   assign rd_acc = psel & penable & ~pwrite & ~pready;
   always_comb begin
      hit = 1'b1;
      rd_mux = 16'h0000;
      case (paddr)
         PBR_ADDR_CTRL: rd_mux = ctrl_r;
         PBR_ADDR_ID_HI: rd_mux = PBR_ID_HI_DEF;
         PBR_ADDR_ID_LO: rd_mux = {PBR_VID_LO_DEF, PBR_MODEL_DEF,
                                   PBR_REV_DEF};
         PBR_ADDR_STS: begin
            rd_mux[PBR_STS_IRQSEEN] = irq_seen_r;
            rd_mux[PBR_STS_LINK] = link_r;
         end
         PBR_ADDR_CFG: rd_mux = cfg_r;
         PBR_ADDR_IRQ_STAT: rd_mux = {13'h0000, ev_stat_r};
         PBR_ADDR_IRQ_MASK: rd_mux = {13'h0000, ev_mask_r};
         default: hit = 1'b0;
      endcase
   end

   // answer one cycle after the access phase starts
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit;
         if (rd_acc) begin
            prdata <= {16'h0000, rd_mux};
         end
      end
   end

   // soft reset is held one cycle then drops itself
   assign all_rst = rst | srst_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         srst_r <= 1'b0;
      end else begin
         srst_r <= wr_acc & (paddr == PBR_ADDR_CTRL) &
                   pwdata[PBR_CTRL_SRST];
      end
   end

   // ----------------------------------------
   // control and configuration
   // ----------------------------------------
   // srst bit reads 1 only while the core is held in reset
   always_ff @(posedge ref_clk) begin
      if (all_rst) begin
         ctrl_r <= PBR_CTRL_RST;
      end else if (wr_acc && paddr == PBR_ADDR_CTRL) begin
         ctrl_r <= (pwdata[15:0] & PBR_CTRL_WMASK) |
                   {pwdata[PBR_CTRL_SRST], 15'h0000};
      end else begin
         ctrl_r[PBR_CTRL_SRST] <= 1'b0;
      end
   end

   // config sits above the 0x0-0xf range so soft reset spares it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_r <= PBR_CFG_RST;
      end else if (wr_acc && paddr == PBR_ADDR_CFG) begin
         cfg_r <= pwdata[15:0] & PBR_CFG_WMASK;
      end
   end

   always_comb begin
      case (cfg_r[PBR_CFG_DEPTH_LO +: 2])
         2'b00: depth = 4'd4;
         2'b01: depth = 4'd5;
         2'b10: depth = 4'd6;
         default: depth = 4'd8;
      endcase
   end

   // ----------------------------------------
   // interrupt pin
   // ----------------------------------------
   assign irq_drive = cfg_r[PBR_CFG_FORCE] |
                      (cfg_r[PBR_CFG_INTEN] & event_pending);
   assign pin_active = cfg_r[PBR_CFG_OE] & irq_drive;
   always_comb begin
      pin_nxt.irq_o = pin_active ^ cfg_r[PBR_CFG_POL];
      pin_nxt.irq_oe_n = ~cfg_r[PBR_CFG_OE];
   end

   // status, link and sticky flags; set beats clear in the same cycle
   assign ev_in[PBR_EV_LINK] = link_up ^ link_d_r;
   assign ev_in[PBR_EV_PIN] = pin_active & ~pin_active_d_r;
   assign ev_in[PBR_EV_SRST] = srst_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         link_d_r <= 1'b0;
         pin_active_d_r <= 1'b0;
      end else begin
         link_d_r <= link_up;
         pin_active_d_r <= pin_active;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (all_rst) begin
         link_r <= 1'b0;
         irq_seen_r <= 1'b0;
      end else begin
         link_r <= link_up;
         if (pin_active) begin
            irq_seen_r <= 1'b1;
         end else if (wr_acc && paddr == PBR_ADDR_STS &&
                      !pwdata[PBR_STS_IRQSEEN]) begin
            irq_seen_r <= 1'b0;
         end
      end
   end

   // soft reset still records its own event in the same cycle that clears the rest
   generate
      for (genvar i = 0; i < PBR_NUM_EV; i++) begin : g_ev
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               ev_stat_r[i] <= 1'b0;
            end else if (ev_in[i]) begin
               ev_stat_r[i] <= 1'b1;
            end else if (srst_r || (rd_acc &&
                         paddr == PBR_ADDR_IRQ_STAT)) begin
               ev_stat_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ev_mask_r <= PBR_MASK_RST;
      end else if (wr_acc && paddr == PBR_ADDR_IRQ_MASK) begin
         ev_mask_r <= pwdata[PBR_NUM_EV-1:0];
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq <= 1'b0;
         shared_irq_sleep_pin_o <= 1'b0;
         shared_irq_sleep_pin_oe_n <= 1'b1;
         core_ctl <= '0;
      end else begin
         irq <= |(ev_stat_r & ev_mask_r);
         shared_irq_sleep_pin_o <= pin_nxt.irq_o;
         shared_irq_sleep_pin_oe_n <= pin_nxt.irq_oe_n;
         core_ctl.loopback <= ctrl_r[PBR_CTRL_LOOP];
         core_ctl.isolate <= ctrl_r[PBR_CTRL_ISO];
         // pin role as input only when not the interrupt output
         core_ctl.power_down <= ctrl_r[PBR_CTRL_PDN] |
            (~cfg_r[PBR_CFG_OE] & shared_irq_sleep_pin_i);
         core_ctl.core_reset <= all_rst;
         core_ctl.debug_mode <= cfg_r[PBR_CFG_DEBUG];
         core_ctl.tx_depth <= depth;
      end
   end
endmodule : pbr_bank

//--- pbr_pkg.sv
package pbr_pkg;
   // ----------------------------------------
   // register offsets (word index, byte = 4x)
   // ----------------------------------------
   localparam int PBR_IDX_CTRL = 'h0;
   localparam int PBR_IDX_ID_HI = 'h2;
   localparam int PBR_IDX_ID_LO = 'h3;
   localparam int PBR_IDX_STS = 'h10;
   localparam int PBR_IDX_CFG = 'h11;
   localparam int PBR_IDX_IRQ_STAT = 'h18;
   localparam int PBR_IDX_IRQ_MASK = 'h19;
   localparam logic [7:0] PBR_ADDR_CTRL = 8'(PBR_IDX_CTRL * 4);
   localparam logic [7:0] PBR_ADDR_ID_HI = 8'(PBR_IDX_ID_HI * 4);
   localparam logic [7:0] PBR_ADDR_ID_LO = 8'(PBR_IDX_ID_LO * 4);
   localparam logic [7:0] PBR_ADDR_STS = 8'(PBR_IDX_STS * 4);
   localparam logic [7:0] PBR_ADDR_CFG = 8'(PBR_IDX_CFG * 4);
   localparam logic [7:0] PBR_ADDR_IRQ_STAT = 8'(PBR_IDX_IRQ_STAT * 4);
   localparam logic [7:0] PBR_ADDR_IRQ_MASK = 8'(PBR_IDX_IRQ_MASK * 4);
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PBR_CTRL_SRST = 15;
   localparam int PBR_CTRL_LOOP = 14;
   localparam int PBR_CTRL_PDN = 11;
   localparam int PBR_CTRL_ISO = 10;
   localparam int PBR_STS_IRQSEEN = 7;
   localparam int PBR_STS_LINK = 0;
   localparam int PBR_CFG_DEBUG = 10;
   localparam int PBR_CFG_DEPTH_LO = 5;
   localparam int PBR_CFG_POL = 3;
   localparam int PBR_CFG_FORCE = 2;
   localparam int PBR_CFG_INTEN = 1;
   localparam int PBR_CFG_OE = 0;
   localparam int PBR_EV_LINK = 0;
   localparam int PBR_EV_PIN = 1;
   localparam int PBR_EV_SRST = 2;
   localparam int PBR_NUM_EV = 3;
   // ----------------------------------------
   // reset values and writable masks
   // ----------------------------------------
   localparam logic [15:0] PBR_CTRL_RST = 16'h0000;
   localparam logic [15:0] PBR_CTRL_WMASK = 16'h4c00;
   localparam logic [15:0] PBR_CFG_RST = 16'h002a;
   localparam logic [15:0] PBR_CFG_WMASK = 16'h0c6f;
   localparam logic [2:0] PBR_MASK_RST = 3'h0;
   // ----------------------------------------
   // identity (values arbitrary)
   // ----------------------------------------
   localparam logic [15:0] PBR_ID_HI_DEF = 16'h5a5a;
   localparam logic [5:0] PBR_VID_LO_DEF = 6'h15;
   localparam logic [4:0] PBR_MODEL_DEF = 5'h03;
   localparam logic [4:0] PBR_REV_DEF = 5'h02;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic loopback;
      logic power_down;
      logic isolate;
      logic core_reset;
      logic debug_mode;
      logic [3:0] tx_depth;
   } pbr_ctl_s;
   typedef struct packed {
      logic irq_o;
      logic irq_oe_n;
   } pbr_pin_s;
endpackage : pbr_pkg

//--- pbr_bank_sva.sv
`timescale 1ns/1ps
// port-level watcher for the register bank
module pbr_bank_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic link_up,
   input wire pbr_pkg::pbr_ctl_s core_ctl
);
   import pbr_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // one wait state, then a single-cycle answer
   ready_on_time_a: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   hole_error_a: assert property (pready && paddr == 8'h04 |-> pslverr)
      else $error("hole accepted");
   id_high_a: assert property (pready && !pwrite && paddr == 8'h08
      |-> prdata == {16'h0000, PBR_ID_HI_DEF}) else $error("bad id high");
   id_low_a: assert property (pready && !pwrite && paddr == 8'h0c
      |-> prdata[15:0] == {PBR_VID_LO_DEF, PBR_MODEL_DEF, PBR_REV_DEF})
      else $error("bad id low");
   // link must have settled for a few cycles before the read means much
   link_read_a: assert property ($stable(link_up) [*4] ##0
      (pready && !pwrite && paddr == 8'h40) |-> prdata[0] == link_up)
      else $error("link bit wrong");
   srst_core_a: assert property (pready && pwrite && paddr == 8'h00
      && pwdata[15] |-> ##[1:3] core_ctl.core_reset)
      else $error("no core reset");
   srst_once_a: assert property (core_ctl.core_reset
      |=> !core_ctl.core_reset) else $error("core reset held");
   mode_write_a: assert property (pready && pwrite && paddr == 8'h00
      && !pwdata[15] |-> ##2 {core_ctl.loopback, core_ctl.isolate} ==
      {$past(pwdata[14], 2), $past(pwdata[10], 2)})
      else $error("mode bits lost");
   depth_code_a: assert property (!$past(rst) && !$past(rst, 2)
      |-> core_ctl.tx_depth inside {4, 5, 6, 8}) else $error("bad depth");
endmodule : pbr_bank_chk

bind pbr_bank pbr_bank_chk u_chk (.ref_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_up,
   .core_ctl);

//--- pbr_host.sv
`timescale 1ns/1ps
// management host: one apb transfer at a time
module pbr_host (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // request held until pready is seen at an edge
   task xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~pwdata; // released data is not left looking valid
      @(posedge ref_clk);
   endtask : xfer
endmodule : pbr_host

//--- tb_phy_basic_register_bank.sv
`timescale 1ns/1ps
module tb_phy_basic_register_bank;
   import pbr_pkg::*;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic link_up, event_pending, pdn_ext, pin_o, pin_oe_n, pin_w;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] seed = 8;
   logic [32:0] exp_q[$];
   pbr_ctl_s core_ctl;
   int bad_count, check_count;
   int dep[4] = '{4, 5, 6, 8};
   // shared pin: host pulls it only while the bank lets go
   assign pin_w = pin_oe_n ? pdn_ext : pin_o;
   initial begin
      ref_clk = 0;
      forever #25 ref_clk = ~ref_clk;
   end
   pbr_host u_host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready);
   pbr_bank u_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .link_up, .event_pending,
      .shared_irq_sleep_pin_i(pin_w), .shared_irq_sleep_pin_o(pin_o),
      .shared_irq_sleep_pin_oe_n(pin_oe_n), .core_ctl, .irq);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction : xs
   task chk(input string n, input logic [32:0] x, input logic [32:0] g);
      check_count++;
      if (x !== g) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, x, g);
      end
   endtask : chk
   task rd(input logic [7:0] a, input logic e, input logic [15:0] d);
      exp_q.push_back({e, 16'h0000, d});
      u_host.xfer(1'b0, a, d);
   endtask : rd
   task wr(input logic [7:0] a, input logic [15:0] d);
      u_host.xfer(1'b1, a, d);
      repeat (3) @(posedge ref_clk);
   endtask : wr
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // read answers against the oldest note, in order
   always @(posedge ref_clk) begin
      if (pready === 1'b1 && pwrite === 1'b0)
         chk("read", exp_q.pop_front(), {pslverr, prdata});
   end
   // cut a hang short well past the expected run
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      {link_up, event_pending, pdn_ext} = '0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      // depth shows its reset code only one edge after release
      repeat (2) @(posedge ref_clk);
      chk("oe", 1, pin_oe_n);
      chk("depth", 5, core_ctl.tx_depth);
      rd(8'h00, 0, 16'h0000);
      rd(8'h40, 0, 16'h0000);
      rd(8'h44, 0, 16'h002a);
      wr(8'h00, 16'h7fff);
      rd(8'h00, 0, 16'h4c00);
      chk("ctl", 3'b111, {core_ctl[8:6]});
      wr(8'h00, 16'h8000);
      rd(8'h00, 0, 16'h0000);
      rd(8'h60, 0, 16'h0004);
      chk("ctl", 0, core_ctl[8:6]);
      pdn_ext <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("pdn", 1, core_ctl.power_down);
      pdn_ext <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         wr(8'h44, 16'h040a | 16'(i << 5));
         rd(8'h44, 0, 16'h040a | 16'(i << 5));
         chk("depth", dep[i], core_ctl.tx_depth);
         chk("dbg", 1, core_ctl.debug_mode);
      end
      wr(8'h44, 16'hffff);
      rd(8'h44, 0, 16'h0c6f);
      chk("pin", 0, pin_w);
      rd(8'h40, 0, 16'h0080);
      wr(8'h44, 16'h002b);
      chk("pin", 1, pin_w);
      wr(8'h40, 16'h0000);
      rd(8'h40, 0, 16'h0000);
      event_pending <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("pin", 0, pin_w);
      wr(8'h44, 16'h0023);
      chk("pin", 1, pin_w);
      wr(8'h44, 16'h0021);
      chk("pin", 0, pin_w);
      event_pending <= 1'b0;
      wr(8'h40, 16'h0000);
      wr(8'h64, 16'h0007);
      chk("irq", 1, irq);
      rd(8'h60, 0, 16'h0002);
      repeat (3) @(posedge ref_clk);
      chk("irq", 0, irq);
      link_up <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(8'h60, 0, 16'h0001);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         link_up <= seed[0];
         event_pending <= seed[1];
         repeat (4) @(posedge ref_clk);
         rd(8'h40, 0, {15'h0000, seed[0]});
      end
      rd(8'h04, 1, 16'h0000);
      wr(8'h08, 16'hffff);
      rd(8'h08, 0, PBR_ID_HI_DEF);
      rd(8'h0c, 0, {PBR_VID_LO_DEF, PBR_MODEL_DEF, PBR_REV_DEF});
      wrap_up();
   end
endmodule : tb_phy_basic_register_bank
